// >>> serial_channel_config.sv
// Contract
// - channels 1,2,7-12 hardware; 3-6 software
// - request to open channel is rejected
// - bad channel, or bad pin on a software channel, rejects request
// - unsupported data width rejects request
// - unconfigured hardware channel defaults to 8-N-1
// - hardware channels ignore pin selections
// - hardware stop count two selects two stops
// - software: one pin may be zero, not both
// - distinct pins: receive input, transmit output unless width is bussed (then shared)
// - same pin: shared line, starts input
// - shared line driven only at active level
// - software channel appends stop bit count
// - stop count out of range gives one
// - idle high, start, LSB first, parity, stops
// - inverted polarity complements the whole frame
`timescale 1ns/1ns
`default_nettype none
module serial_channel_config (
   input wire logic I_MCLK,
   input wire logic I_ARST_N,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [31:0] I_PIN_IN,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   output logic [31:0] O_PIN_OUT,
   output logic [31:0] O_PIN_OE
);
   ////////////////////////////////////////////////////////////////////////////
   // decoding helpers
   function automatic logic is_hw(input logic [3:0] c);
      is_hw = (c == scc_pkg::CH_HW_A) | (c == scc_pkg::CH_HW_B) |
              ((c >= scc_pkg::CH_HW_LO) & (c <= scc_pkg::CH_HW_HI));
   endfunction : is_hw

   function automatic logic is_sw(input logic [3:0] c);
      is_sw = (c >= scc_pkg::CH_SW_LO) & (c <= scc_pkg::CH_SW_HI);
   endfunction : is_sw

   function automatic logic [31:0] pin_hot(input logic [7:0] p);
      pin_hot = (p == 8'h00 || p > scc_pkg::PIN_MAX) ? 32'h0000_0000 : (32'h0000_0001 << (p - 8'h01));
   endfunction : pin_hot

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [15:0] pins_r, open_r, defined_r, div_r;
   logic [16:0] fmt_r;
   logic [3:0] sel_r, txch_r;
   logic [7:0] txbyte_r, act_pin_r;
   logic [1:0] pend_r;
   logic st_ok_r, st_rej_r;
   logic [31:0] dir_r, shared_r, idle_r, pin_out_r, pin_oe_r, pin_s1_r, pin_s2_r;
   logic [31:0] prdata_r;
   logic pready_r, pslverr_r;

   frame_if fr ();

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire acc = I_PSEL & I_PENABLE;
   wire wr_go = acc & I_PWRITE & pready_r;
   wire rd_cap = acc & ~pready_r;
   wire hit_cmd = (I_PADDR == scc_pkg::A_CMD);
   wire hit_pins = (I_PADDR == scc_pkg::A_PINS);
   wire hit_fmt = (I_PADDR == scc_pkg::A_FMT);
   wire hit_stat = (I_PADDR == scc_pkg::A_STAT);
   wire hit_open = (I_PADDR == scc_pkg::A_OPEN);
   wire hit_div = (I_PADDR == scc_pkg::A_DIV);
   wire hit_txd = (I_PADDR == scc_pkg::A_TXD);
   wire hit_cfg = (I_PADDR == scc_pkg::A_CFG);
   wire hit_sel = (I_PADDR == scc_pkg::A_SEL);
   wire hit_pin = (I_PADDR == scc_pkg::A_PIN);
   wire hit_lo = hit_cmd | hit_pins | hit_fmt | hit_stat;
   wire hit_mid = hit_open | hit_div | hit_txd;
   wire hit_hi = hit_cfg | hit_sel | hit_pin;
   wire mapped = hit_lo | hit_mid | hit_hi;

   ////////////////////////////////////////////////////////////////////////////
   // request validation
   wire [3:0] req_ch = I_PWDATA[3:0];
   wire [7:0] rx = pins_r[scc_pkg::PINS_RX_LSB +: 8];
   wire [7:0] tx = pins_r[scc_pkg::PINS_TX_LSB +: 8];
   wire [7:0] flags = fmt_r[scc_pkg::FMT_FLAGS_LSB +: 8];
   wire [7:0] scnt = fmt_r[scc_pkg::FMT_STOP_LSB +: 8];
   wire given = fmt_r[scc_pkg::FMT_GIVEN_BIT];
   wire [3:0] wcode = flags[3:0];
   wire ch_hw = is_hw(req_ch);
   wire ch_sw = is_sw(req_ch);
   wire rx_ok = (rx <= scc_pkg::PIN_MAX);
   wire tx_ok = (tx <= scc_pkg::PIN_MAX);
   wire sw_pins_ok = rx_ok & tx_ok & ~((rx == 8'h00) & (tx == 8'h00));
   wire hw_w_ok = (wcode == scc_pkg::W5) | (wcode == scc_pkg::W6) |
                  (wcode == scc_pkg::W7) | (wcode == scc_pkg::W8);
   wire sw_w_ok = (wcode == scc_pkg::W5) | (wcode == scc_pkg::W7) | (wcode == scc_pkg::W8) |
                  (wcode == scc_pkg::W7B) | (wcode == scc_pkg::W8B);
   wire width_ok = ch_hw ? hw_w_ok : sw_w_ok;
   wire ch_valid = ch_hw | ch_sw;
   wire req_ok = ch_valid & ~open_r[req_ch] & width_ok & (ch_hw | sw_pins_ok);
   wire [7:0] hw_stops = (given & (scnt == scc_pkg::TWO_STOPS)) ? scc_pkg::TWO_STOPS : scc_pkg::ONE_STOP;
   wire [7:0] sw_stops = (given & (scnt >= scc_pkg::ONE_STOP) & (scnt <= scc_pkg::SW_MAX_STOPS)) ?
                         scnt : scc_pkg::ONE_STOP;
   wire cmd_go = wr_go & hit_cmd;
   wire apply = cmd_go & req_ok;
   wire [7:0] cfg_stops = ch_hw ? hw_stops : sw_stops;
   wire [7:0] cfg_rx = ch_hw ? 8'h00 : rx;
   wire [7:0] cfg_tx = ch_hw ? 8'h00 : tx;
   wire [31:0] cfg_wdata = {flags, cfg_stops, cfg_rx, cfg_tx};

   ////////////////////////////////////////////////////////////////////////////
   // pin direction planning
   wire [31:0] rx_hot = pin_hot(rx);
   wire [31:0] tx_hot = pin_hot(tx);
   wire same = (rx == tx);
   wire bussed = (wcode == scc_pkg::W7B) | (wcode == scc_pkg::W8B);
   wire inv_req = flags[scc_pkg::FL_INV_BIT];
   wire pin_apply = apply & ch_sw;
   wire [31:0] dir_nxt = (dir_r & ~rx_hot & ~tx_hot) | (same ? 32'h0000_0000 : tx_hot);
   wire [31:0] shared_nxt = (shared_r & ~rx_hot & ~tx_hot) | ((same | bussed) ? tx_hot : 32'h0000_0000);
   wire [31:0] idle_nxt = (idle_r & ~tx_hot) | (inv_req ? 32'h0000_0000 : tx_hot);

   ////////////////////////////////////////////////////////////////////////////
   // transmit launch
   logic [31:0] mem_rdata;
   wire [3:0] txd_ch = I_PWDATA[scc_pkg::TXD_CH_LSB +: 4];
   wire txd_hit = wr_go & hit_txd;
   wire tx_free = ~fr.busy & (pend_r == 2'b00);
   wire txd_ch_ok = is_sw(txd_ch) & defined_r[txd_ch] & open_r[txd_ch];
   wire txd_go = txd_hit & tx_free & txd_ch_ok;
   wire [3:0] mem_raddr = (|pend_r) ? txch_r : sel_r;
   wire [7:0] rd_flags = mem_rdata[scc_pkg::CFG_FLAGS_LSB +: 8];
   wire [7:0] rd_tx = mem_rdata[scc_pkg::CFG_TX_LSB +: 8];
   wire [3:0] rd_w = rd_flags[3:0];

   cfg_mem u_mem (
      .i_clk(I_MCLK),
      .i_arst_n(I_ARST_N),
      .i_we(apply),
      .i_waddr(req_ch),
      .i_wdata(cfg_wdata),
      .i_raddr(mem_raddr),
      .o_rdata(mem_rdata)
   );

   assign fr.start = pend_r[1] & (rd_tx != 8'h00);
   assign fr.data = txbyte_r;
   assign fr.nbits = (rd_w == scc_pkg::W7B) ? scc_pkg::W7 : (rd_w == scc_pkg::W8B) ? scc_pkg::W8 : rd_w;
   assign fr.par_en = rd_flags[scc_pkg::FL_PAR_EN_BIT];
   assign fr.par_odd = ~rd_flags[scc_pkg::FL_PAR_EVEN_BIT];
   assign fr.inv = rd_flags[scc_pkg::FL_INV_BIT];
   assign fr.stops = mem_rdata[scc_pkg::CFG_STOP_LSB +: 8];
   assign fr.div = div_r;

   frame_tx u_tx (
      .i_clk(I_MCLK),
      .i_arst_n(I_ARST_N),
      .f(fr.sink)
   );

   ////////////////////////////////////////////////////////////////////////////
   // pin drive
   wire [31:0] act_hot = pin_hot(act_pin_r);
   wire [31:0] out_nxt, oe_nxt;
   genvar gp;
   generate
      for (gp = 0; gp < scc_pkg::NUM_PINS; gp = gp + 1) begin : g_pin
         wire drv = fr.busy & act_hot[gp];
         assign out_nxt[gp] = drv ? fr.line : idle_r[gp];
         assign oe_nxt[gp] = shared_r[gp] ? (drv & (fr.line != idle_r[gp])) : dir_r[gp];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   // default 8-N-1 word
   wire [31:0] hw_default = {scc_pkg::HW_DEF_FLAGS, scc_pkg::ONE_STOP, 16'h0000};
   wire [31:0] cfg_rd = defined_r[sel_r] ? mem_rdata : (is_hw(sel_r) ? hw_default : 32'h0000_0000);
   wire [31:0] stat_rd = {28'h0000_000, fr.busy, |pend_r, st_rej_r, st_ok_r};
   wire [31:0] rd_mux = hit_pins ? {16'h0000, pins_r} :
                        hit_fmt ? {15'h0000, fmt_r} :
                        hit_stat ? stat_rd :
                        hit_open ? {16'h0000, open_r} :
                        hit_div ? {16'h0000, div_r} :
                        hit_cfg ? cfg_rd :
                        hit_sel ? {28'h0000_000, sel_r} :
                        hit_pin ? pin_s2_r : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave
   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= rd_cap;
         pslverr_r <= rd_cap & ~mapped;
         if (rd_cap & ~I_PWRITE) begin
            prdata_r <= rd_mux;
         end
      end
   end

   // software registers
   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         pins_r <= 16'h0000;
         fmt_r <= 17'h00000;
         open_r <= 16'h0000;
         div_r <= scc_pkg::DIV_RST;
         sel_r <= 4'h0;
      end else if (wr_go) begin
         if (hit_pins) begin
            pins_r <= I_PWDATA[15:0];
         end
         if (hit_fmt) begin
            fmt_r <= I_PWDATA[16:0];
         end
         if (hit_open) begin
            open_r <= I_PWDATA[15:0] & scc_pkg::CH_MASK;
         end
         if (hit_div) begin
            div_r <= I_PWDATA[15:0];
         end
         if (hit_sel) begin
            sel_r <= I_PWDATA[3:0];
         end
      end
   end

   // request outcome and channel state
   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         st_ok_r <= 1'b0;
         st_rej_r <= 1'b0;
         defined_r <= 16'h0000;
         dir_r <= 32'h0000_0000;
         shared_r <= 32'h0000_0000;
         idle_r <= 32'h0000_0000;
      end else begin
         if (cmd_go) begin
            st_ok_r <= req_ok;
            st_rej_r <= ~req_ok;
         end
         if (apply) begin
            defined_r[req_ch] <= 1'b1;
         end
         if (pin_apply) begin
            dir_r <= dir_nxt;
            shared_r <= shared_nxt;
            idle_r <= idle_nxt;
         end
      end
   end

   // transmit pipeline and pins
   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         pend_r <= 2'b00;
         txch_r <= 4'h0;
         txbyte_r <= 8'h00;
         act_pin_r <= 8'h00;
         pin_out_r <= 32'h0000_0000;
         pin_oe_r <= 32'h0000_0000;
         pin_s1_r <= 32'h0000_0000;
         pin_s2_r <= 32'h0000_0000;
      end else begin
         pend_r <= {pend_r[0], txd_go};
         if (txd_go) begin
            txch_r <= txd_ch;
            txbyte_r <= I_PWDATA[7:0];
         end
         if (fr.start) begin
            act_pin_r <= rd_tx;
         end
         pin_out_r <= out_nxt;
         pin_oe_r <= oe_nxt;
         pin_s1_r <= I_PIN_IN;
         pin_s2_r <= pin_s1_r;
      end
   end

   assign O_PRDATA = prdata_r;
   assign O_PREADY = pready_r;
   assign O_PSLVERR = pslverr_r;
   assign O_PIN_OUT = pin_out_r;
   assign O_PIN_OE = pin_oe_r;
endmodule : serial_channel_config
`default_nettype wire

// >>> scc_pkg.sv
`default_nettype none
package scc_pkg;
   localparam int NUM_PINS = 32;
   localparam logic [7:0] PIN_MAX = 8'h20;
   // register byte offsets
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_PINS = 8'h04;
   localparam logic [7:0] A_FMT = 8'h08;
   localparam logic [7:0] A_STAT = 8'h0C;
   localparam logic [7:0] A_OPEN = 8'h10;
   localparam logic [7:0] A_DIV = 8'h14;
   localparam logic [7:0] A_TXD = 8'h18;
   localparam logic [7:0] A_CFG = 8'h1C;
   localparam logic [7:0] A_SEL = 8'h20;
   localparam logic [7:0] A_PIN = 8'h24;
   // field positions
   localparam int PINS_RX_LSB = 0;
   localparam int PINS_TX_LSB = 8;
   localparam int FMT_FLAGS_LSB = 0;
   localparam int FMT_STOP_LSB = 8;
   localparam int FMT_GIVEN_BIT = 16;
   localparam int TXD_CH_LSB = 8;
   localparam int CFG_TX_LSB = 0;
   localparam int CFG_RX_LSB = 8;
   localparam int CFG_STOP_LSB = 16;
   localparam int CFG_FLAGS_LSB = 24;
   localparam int FL_INV_BIT = 7;
   localparam int FL_PAR_EN_BIT = 5;
   localparam int FL_PAR_EVEN_BIT = 4;
   // data width codes
   localparam logic [3:0] W5 = 4'h5;
   localparam logic [3:0] W6 = 4'h6;
   localparam logic [3:0] W7 = 4'h7;
   localparam logic [3:0] W8 = 4'h8;
   localparam logic [3:0] W7B = 4'hB;
   localparam logic [3:0] W8B = 4'hC;
   // channel classes
   localparam logic [3:0] CH_HW_A = 4'h1;
   localparam logic [3:0] CH_HW_B = 4'h2;
   localparam logic [3:0] CH_SW_LO = 4'h3;
   localparam logic [3:0] CH_SW_HI = 4'h6;
   localparam logic [3:0] CH_HW_LO = 4'h7;
   localparam logic [3:0] CH_HW_HI = 4'hC;
   localparam logic [15:0] CH_MASK = 16'h1FFE;
   // reset values and limits
   localparam logic [15:0] DIV_RST = 16'h0410;
   localparam logic [7:0] HW_DEF_FLAGS = 8'h08;
   localparam logic [7:0] ONE_STOP = 8'h01;
   localparam logic [7:0] TWO_STOPS = 8'h02;
   localparam logic [7:0] SW_MAX_STOPS = 8'hF0;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_e;
endpackage : scc_pkg
`default_nettype wire

// >>> frame_if.sv
`timescale 1ns/1ns
`default_nettype none
interface frame_if;
   logic start;
   logic [7:0] data;
   logic [3:0] nbits;
   logic par_en;
   logic par_odd;
   logic inv;
   logic [7:0] stops;
   logic [15:0] div;
   logic line;
   logic busy;
   modport src(output start, data, nbits, par_en, par_odd, inv, stops, div, input line, busy);
   modport sink(input start, data, nbits, par_en, par_odd, inv, stops, div, output line, busy);
endinterface : frame_if
`default_nettype wire

// >>> cfg_mem.sv
`timescale 1ns/1ns
`default_nettype none
module cfg_mem (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_we,
   input wire logic [3:0] i_waddr,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_raddr,
   output logic [31:0] o_rdata
);
   logic [31:0] mem [0:15];
   logic [31:0] rdata_r;

   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= mem[i_raddr];
      end
   end

   assign o_rdata = rdata_r;
endmodule : cfg_mem
`default_nettype wire

// >>> frame_tx.sv
`timescale 1ns/1ns
`default_nettype none
module frame_tx (
   input wire logic i_clk,
   input wire logic i_arst_n,
   frame_if.sink f
);
   scc_pkg::tx_state_e state_r, state_nxt;
   logic [15:0] cnt_r, div_r;
   logic [7:0] shift_r, shift_nxt, stop_r, stop_nxt, stops_r;
   logic [3:0] bit_r, bit_nxt;
   logic par_r, par_en_r, inv_r, raw_nxt, line_r, busy_r;
   logic tick;
   logic [7:0] mask;
   logic par_calc;

   assign tick = (cnt_r == 16'h0000);
   assign mask = 8'hFF >> (4'h8 - f.nbits);
   assign par_calc = (^(f.data & mask)) ^ f.par_odd;

   // element sequencing
   always_comb begin
      state_nxt = state_r;
      shift_nxt = shift_r;
      bit_nxt = bit_r;
      stop_nxt = stop_r;
      raw_nxt = 1'b1;
      case (state_r)
         scc_pkg::TX_IDLE: begin
            if (f.start) begin
               state_nxt = scc_pkg::TX_START;
               shift_nxt = f.data;
               bit_nxt = f.nbits;
               raw_nxt = 1'b0;
            end
         end
         scc_pkg::TX_START: begin
            raw_nxt = 1'b0;
            if (tick) begin
               state_nxt = scc_pkg::TX_DATA;
               raw_nxt = shift_r[0];
            end
         end
         scc_pkg::TX_DATA: begin
            raw_nxt = shift_r[0];
            if (tick) begin
               if (bit_r == 4'h1) begin
                  state_nxt = par_en_r ? scc_pkg::TX_PARITY : scc_pkg::TX_STOP;
                  raw_nxt = par_en_r ? par_r : 1'b1;
                  stop_nxt = stops_r;
               end else begin
                  shift_nxt = shift_r >> 1;
                  bit_nxt = bit_r - 4'h1;
                  raw_nxt = shift_r[1];
               end
            end
         end
         scc_pkg::TX_PARITY: begin
            raw_nxt = par_r;
            if (tick) begin
               state_nxt = scc_pkg::TX_STOP;
               raw_nxt = 1'b1;
            end
         end
         scc_pkg::TX_STOP: begin
            if (tick) begin
               if (stop_r == 8'h01) begin
                  state_nxt = scc_pkg::TX_IDLE;
               end else begin
                  stop_nxt = stop_r - 8'h01;
               end
            end
         end
         default: begin
            state_nxt = scc_pkg::TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r <= scc_pkg::TX_IDLE;
         cnt_r <= 16'h0000;
         div_r <= 16'h0000;
         shift_r <= 8'h00;
         bit_r <= 4'h0;
         stop_r <= 8'h00;
         stops_r <= 8'h00;
         par_r <= 1'b0;
         par_en_r <= 1'b0;
         inv_r <= 1'b0;
         line_r <= 1'b1;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         shift_r <= shift_nxt;
         bit_r <= bit_nxt;
         stop_r <= stop_nxt;
         busy_r <= (state_nxt != scc_pkg::TX_IDLE);
         if (state_r == scc_pkg::TX_IDLE) begin
            cnt_r <= f.div;
            div_r <= f.div;
         end else begin
            cnt_r <= tick ? div_r : cnt_r - 16'h0001;
         end
         if (state_r == scc_pkg::TX_IDLE && f.start) begin
            stops_r <= f.stops;
            par_r <= par_calc;
            par_en_r <= f.par_en;
            inv_r <= f.inv;
         end
         line_r <= raw_nxt ^ ((state_r == scc_pkg::TX_IDLE && f.start) ? f.inv : inv_r);
      end
   end

   assign f.line = line_r;
   assign f.busy = busy_r;
endmodule : frame_tx
`default_nettype wire

// >>> scc_props.sv
`timescale 1ns/1ns
`default_nettype none
module scc_props (
   input wire logic I_MCLK,
   input wire logic I_ARST_N,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [31:0] I_PIN_IN,
   input wire logic [31:0] O_PRDATA,
   input wire logic O_PREADY,
   input wire logic O_PSLVERR,
   input wire logic [31:0] O_PIN_OUT,
   input wire logic [31:0] O_PIN_OE
);
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_ARST_N);
   ////////////////////////////////////////////////////////////////
   ready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
      else $error("ready longer than one cycle");
   access_wait_a: assert property (I_PSEL && $rose(I_PENABLE) |-> !O_PREADY ##1 O_PREADY)
      else $error("access not ended after one wait state");
   ready_access_a: assert property (O_PREADY |-> I_PSEL && I_PENABLE && $past(I_PENABLE))
      else $error("ready outside access phase");
   err_ready_a: assert property (O_PSLVERR |-> O_PREADY)
      else $error("error without ready");
   err_unmapped_a: assert property (O_PREADY && I_PADDR > 8'h24 |-> O_PSLVERR)
      else $error("unmapped access without error");
   no_err_mapped_a: assert property (O_PREADY && I_PADDR <= 8'h24 && I_PADDR[1:0] == 2'h0 |-> !O_PSLVERR)
      else $error("mapped access flagged as error");
   rdata_holds_a: assert property ($changed(O_PRDATA) |-> O_PREADY && !I_PWRITE)
      else $error("read data moved outside a read");
   err_reads_zero_a: assert property (O_PREADY && O_PSLVERR && !I_PWRITE |-> O_PRDATA == 32'h0)
      else $error("unmapped read not zero");
endmodule : scc_props
bind serial_channel_config scc_props u_props (.I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N), .I_PSEL(I_PSEL),
   .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .I_PIN_IN(I_PIN_IN),
   .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_PIN_OUT(O_PIN_OUT), .O_PIN_OE(O_PIN_OE));
`default_nettype wire

// >>> far_end.sv
`timescale 1ns/1ns
`default_nettype none
module far_end (
   input wire logic [31:0] i_pin_out,
   input wire logic [31:0] i_pin_oe,
   input wire logic [31:0] i_pull_dn,
   output logic [31:0] o_line
);
   assign o_line = (i_pin_oe & i_pin_out) | (~i_pin_oe & ~i_pull_dn);
endmodule : far_end
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk, rst_n, psel, pen, pwr, rdy, err, e;
   logic [7:0] padr;
   logic [31:0] pwd, prd, pin_out, pin_oe, ln, pull_dn, q;
   logic [31:0] cfgm [16];
   logic [15:0] opn;
   logic [15:0] lf = 16'h3002;
   logic [27:0] tbl [14] = '{28'h0080101, 28'hD080101, 28'h1080201, 28'h2060301, 28'h7070200, 28'hC050101,
      28'h90B0101, 28'hA040101, 28'h387F001, 28'h435F101, 28'h50C0001, 28'h6060101, 28'h3080500, 28'h62B0201};
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   serial_channel_config u_dut (.I_MCLK(clk), .I_ARST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
      .I_PADDR(padr), .I_PWDATA(pwd), .I_PIN_IN(ln), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err),
      .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe));
   far_end u_far (.i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_pull_dn(pull_dn), .o_line(ln));
   ////////////////////////////////////////////////////////////////
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : nxt
   task automatic final_report;
      $display("mismatches %0d, comparisons %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      tests_run++;
      if (g !== x) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pen <= 1'h0;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'h1;
      @(posedge clk);
      while (rdy !== 1'h1) @(posedge clk);
      q = prd;
      e = err;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask : apb
   task automatic op(input logic [15:0] m);
      opn = m;
      apb(1'h1, scc_pkg::A_OPEN, {16'h0, m});
   endtask : op
   task automatic cfg_rd(input logic [3:0] ch);
      apb(1'h1, scc_pkg::A_SEL, {28'h0, ch});
      apb(1'h0, scc_pkg::A_CFG, 32'h0);
      chk(q, cfgm[ch]);
   endtask : cfg_rd
   task automatic cfg(input logic [3:0] ch, input logic [7:0] rx, input logic [7:0] tx, input logic [7:0] fl,
      input logic [7:0] sb, input logic gv);
      logic hw, sw, ok;
      logic [7:0] st;
      hw = ch inside {4'h1, 4'h2, [4'h7:4'hC]};
      sw = ch inside {[4'h3:4'h6]};
      ok = (hw && fl[3:0] inside {[4'h5:4'h8]}) || (sw && fl[3:0] inside {4'h5, 4'h7, 4'h8, 4'hB, 4'hC}
         && rx <= 8'h20 && tx <= 8'h20 && (rx | tx) != 8'h0);
      ok = ok && !opn[ch];
      st = hw ? ((gv && sb == 8'h02) ? 8'h02 : 8'h01) : ((gv && sb != 8'h00 && sb <= 8'hF0) ? sb : 8'h01);
      if (ok) cfgm[ch] = {fl, st, hw ? 16'h0 : {rx, tx}};
      apb(1'h1, scc_pkg::A_PINS, {16'h0, tx, rx});
      apb(1'h1, scc_pkg::A_FMT, {15'h0, gv, sb, fl});
      apb(1'h1, scc_pkg::A_CMD, {28'h0, ch});
      apb(1'h0, scc_pkg::A_STAT, 32'h0);
      chk({30'h0, q[1:0]}, ok ? 32'h1 : 32'h2);
      cfg_rd(ch);
   endtask : cfg
   task automatic frame(input logic [3:0] ch, input int p, input logic inv, input logic [7:0] b, input int ns);
      logic x;
      apb(1'h1, scc_pkg::A_TXD, {20'h0, ch, b});
      @(negedge clk);
      while (ln[p-1] === !inv) @(negedge clk);
      repeat (2) @(negedge clk);
      for (int i = 0; i < 9 + ns; i++) begin
         x = (i == 0) ? 1'h0 : (i < 9) ? b[i-1] : 1'h1;
         chk({31'h0, ln[p-1]}, {31'h0, x ^ inv});
         chk({31'h0, pin_oe[p-1]}, {31'h0, !x});
         repeat (4) @(negedge clk);
      end
      chk({31'h0, ln[p-1]}, {31'h0, !inv});
   endtask : frame
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         final_report();
      end
   end
   initial begin
      {psel, pen, pwr, rst_n, padr, pwd, pull_dn, opn} = '0;
      for (int c = 0; c < 16; c++) cfgm[c] = (c inside {1, 2, [7:12]}) ? 32'h08010000 : 32'h0;
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      apb(1'h0, scc_pkg::A_DIV, 32'h0);
      chk(q, {16'h0, scc_pkg::DIV_RST});
      apb(1'h0, 8'h28, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      cfg_rd(4'h1);
      cfg_rd(4'h3);
      foreach (tbl[k]) begin
         lf = nxt(lf);
         cfg(tbl[k][27:24], lf[7:0] % 8'h22, lf[15:8] % 8'h22, tbl[k][23:16], tbl[k][15:8], tbl[k][0]);
      end
      op(16'h0010);
      cfg(4'h4, 8'h01, 8'h02, 8'h08, 8'h01, 1'h1);
      op(16'h0000);
      cfg(4'h3, 8'h00, 8'h09, 8'h08, 8'h01, 1'h1);
      cfg(4'h3, 8'h00, 8'h00, 8'h08, 8'h01, 1'h1);
      cfg(4'h4, 8'h0A, 8'h0B, 8'h08, 8'h01, 1'h1);
      chk({29'h0, pin_oe[10], pin_oe[9], pin_out[10]}, 32'h5);
      apb(1'h1, scc_pkg::A_DIV, 32'h3);
      cfg(4'h5, 8'h14, 8'h14, 8'h08, 8'h02, 1'h1);
      chk({31'h0, pin_oe[19]}, 32'h0);
      op(16'h0020);
      lf = nxt(lf);
      frame(4'h5, 20, 1'h0, lf[7:0], 2);
      op(16'h0000);
      pull_dn <= 32'h00200000;
      cfg(4'h6, 8'h16, 8'h16, 8'h88, 8'h01, 1'h1);
      op(16'h0040);
      frame(4'h6, 22, 1'h1, lf[15:8], 1);
      apb(1'h0, scc_pkg::A_PIN, 32'h0);
      chk(q, ln);
      final_report();
   end
endmodule : tb
`default_nettype wire
